/* rtl/ldo_pkg.sv */
// Package for the loop detector channel option logic.
// Assumes one 250 MHz clock and two channels per detector card.
package ldo_pkg;
    localparam int LDO_CLK_HZ = 250_000_000;
    // Audible auto-off time in minutes, and its cycle count
    localparam longint LDO_AUD_MIN = 15;
    localparam longint LDO_AUD_CYC = LDO_AUD_MIN * 60 * LDO_CLK_HZ;
    // Desensitise spread time in seconds, and its cycle count
    localparam longint LDO_DES_SEC = 15;
    localparam longint LDO_DES_CYC = LDO_DES_SEC * LDO_CLK_HZ;
    // Desensitise step in hundredths of a percent of -dL/L
    localparam logic [7:0] LDO_DES_HUND = 8'h05;
    // Filter length in cycles, used when the noise filter is on
    localparam int LDO_FILT_CYC = 16;
    // Loop configuration range (settings 7.01 .. 7.05)
    localparam logic [2:0] LDO_LOOPS_MIN = 3'h1;
    localparam logic [2:0] LDO_LOOPS_MAX = 3'h5;
    localparam logic [15:0] LDO_CNT_RST = 16'h0000;
    localparam logic [15:0] LDO_CNT_DISP_LIM = 16'h03e7;
    // Display alternation period in cycles
    localparam int LDO_ALT_CYC = 250_000_000;

    // Per-channel settings
    typedef struct packed {
        logic pg_comp_en;
        logic cnt_disp_en;
        logic cnt_reset;
        logic [2:0] loops;
        logic disc_en;
        logic disc_sub;
        logic aud_req;
    } ldo_chcfg_t;

    // Per-channel status from the block
    typedef struct packed {
        logic call;
        logic fail;
        logic pending;
        logic ext_run;
        logic [7:0] desens;
    } ldo_chsts_t;

    // Count display frame
    typedef struct packed {
        logic upper;
        logic [9:0] value;
    } ldo_disp_t;
endpackage : ldo_pkg

/* rtl/ldo_chan.sv */
// One detector channel: filter, extension, disconnect, compensation, counter.
// Assumes presence and phase green arrive already synchronised to mclk.
module ldo_chan
    import ldo_pkg::*;
#(
    parameter int EXT_W = 32,
    parameter longint DES_CYC = LDO_DES_CYC
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic filt_off,
    input wire logic occ_raw,
    input wire logic green,
    input wire logic [EXT_W-1:0] ext_cyc,
    input wire logic timers_off,
    input wire logic call_in,
    input wire ldo_chcfg_t cfg,
    output logic occ,
    output logic ext_run,
    output logic disc,
    output logic [7:0] desens,
    output logic [15:0] count
);
    logic [4:0] filt_r;
    logic occ_d_r;
    logic [EXT_W-1:0] ext_r;
    logic [31:0] des_cnt_r;
    logic cnt_rst_d_r;
    logic [2:0] veh_r;
    logic [2:0] loops_eff;

    // Filter: input must hold for a run of cycles unless bypassed
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            filt_r <= 5'h00;
            occ <= 1'b0;
        end else if (filt_off) begin
            occ <= occ_raw;
            filt_r <= 5'h00;
        end else if (occ_raw == occ) begin
            filt_r <= 5'h00;
        end else if (filt_r == 5'(LDO_FILT_CYC - 1)) begin
            occ <= occ_raw;
            filt_r <= 5'h00;
        end else begin
            filt_r <= filt_r + 5'h01;
        end
    end

    // Extension counts from last exit, restarts fully on entry
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            occ_d_r <= 1'b0;
            ext_r <= '0;
        end else begin
            occ_d_r <= occ;
            if (timers_off)
                ext_r <= '0;
            else if (occ)
                ext_r <= ext_cyc; // Held full while occupied: no call gap at the exit edge
            else if (ext_r != '0)
                ext_r <= ext_r - 1'b1;
        end
    end
    // In sub-mode on the timer does not hold the call during green
    assign ext_run = (ext_r != '0) && !occ && !(cfg.disc_en && cfg.disc_sub && green);

    // Disconnect latches when gap expires in green, clears off green
    always_ff @(posedge mclk) begin
        if (!rstn || !green || !cfg.disc_en || timers_off)
            disc <= 1'b0;
        else if (occ_d_r && !occ && ext_cyc == '0)
            disc <= 1'b1;
        else if (!occ && ext_r == {{(EXT_W-1){1'b0}}, 1'b1})
            disc <= 1'b1;
    end

    // Desensitise ramp during green with a call, held in green without one, normal off green
    always_ff @(posedge mclk) begin
        if (!rstn || !cfg.pg_comp_en || !green) begin
            des_cnt_r <= 32'h0;
            desens <= 8'h00;
        end else if (call_in && des_cnt_r != 32'(DES_CYC)) begin
            des_cnt_r <= des_cnt_r + 32'h1;
            desens <= 8'((64'(des_cnt_r) + 64'h1) * 64'(LDO_DES_HUND) / 64'(DES_CYC));
        end
    end

    // Out-of-range loop settings count as the nearest legal one
    assign loops_eff = (cfg.loops < LDO_LOOPS_MIN) ? LDO_LOOPS_MIN :
        ((cfg.loops > LDO_LOOPS_MAX) ? LDO_LOOPS_MAX : cfg.loops);

    // Count vehicles per lane loop group, reset on off-to-on
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            count <= LDO_CNT_RST;
            cnt_rst_d_r <= 1'b0;
            veh_r <= 3'h0;
        end else begin
            cnt_rst_d_r <= cfg.cnt_reset;
            if (cfg.cnt_reset && !cnt_rst_d_r) begin
                count <= LDO_CNT_RST;
                veh_r <= 3'h0;
            end else if (occ && !occ_d_r) begin
                if (veh_r + 3'h1 >= loops_eff) begin
                    veh_r <= 3'h0;
                    count <= count + 16'h0001;
                end else begin
                    veh_r <= veh_r + 3'h1;
                end
            end
        end
    end
endmodule : ldo_chan

/* rtl/ldo_top.sv */
// Option logic for a two-channel inductive loop detector.
// Assumes occupancy, fail and phase green arrive as pins from other domains.
// How it works
// - Noise filter bypassed when option on
// - Filter setting shared; change resets whole detector
// - Filter option defaults off after reset
// - Green with call desensitises 0.05% over 15s
// - Compensation per channel; normal otherwise
// - Count display replaces normal display
// - Counter wraps 65535 to zero
// - Three digits to 999, then alternate
// - Off-to-on reset clears count; reads off
// - Loop setting 7.01 to 7.05 per channel
// - Common fail drives both fail outputs
// - Third car: call both only when both occupied
// - Third car: first channel shows pending
// - Directional: first channel pending, no call
// - Directional: later channel calls until its end
// - Directional: first channel runs no timers
// - Buzzer follows selected channel occupancy
// - Audible on at most one channel
// - Audible switches off after 15 minutes
// - Disconnect: gap expiry in green suppresses call
// - Sub-mode off: extension doubles as disconnect
// - Sub-mode on: call follows occupancy in green until gap expiry
// - Extension restarts fully on new entry
module ldo_top
    import ldo_pkg::*;
#(
    parameter int EXT_W = 32,
    parameter longint AUD_CYC = LDO_AUD_CYC,
    parameter longint DES_CYC = LDO_DES_CYC,
    parameter int ALT_CYC = LDO_ALT_CYC
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [1:0] occ_pin,
    input wire logic [1:0] loop_fail_pin,
    input wire logic [1:0] phase_green_n,
    input wire logic filt_off,
    input wire logic common_fail_en,
    input wire logic third_car_en,
    input wire logic dir_logic_en,
    input wire ldo_chcfg_t [1:0] ch_cfg,
    input wire logic [1:0][EXT_W-1:0] ext_cyc,
    output ldo_chsts_t [1:0] ch_sts,
    output logic [1:0] cnt_disp_on,
    output ldo_disp_t [1:0] cnt_disp,
    output logic [1:0] aud_sel,
    output logic buzzer,
    output logic [1:0] cnt_reset_view,
    output logic [1:0][2:0] loops_cfg,
    output logic det_reset
);
    logic [1:0] occ_s1_r, occ_s2_r, fail_s1_r, fail_s2_r, grn_s1_r, grn_s2_r;
    logic filt_r;
    logic [1:0] occ;
    logic [1:0] ext_run;
    logic [1:0] disc;
    logic [1:0][7:0] desens;
    logic [1:0][15:0] count;
    logic [1:0] timers_off;
    logic [1:0] chan_call;
    logic [1:0] call_nxt;
    logic [1:0] pend_nxt;
    logic [1:0] fail_nxt;
    logic [1:0] first_r;
    logic [1:0] aud_r;
    logic [1:0] aud_req_d_r;
    logic [63:0] aud_cnt_r;
    logic [31:0] alt_cnt_r;
    logic alt_r;
    logic [1:0][2:0] loops_r;
    logic [1:0] call_r;

    typedef enum logic [2:0] {
        LDO_DIR_IDLE = 3'b001,
        LDO_DIR_PEND = 3'b010,
        LDO_DIR_CALL = 3'b100
    } ldo_dir_t;
    ldo_dir_t dir_r;

    // Clamp the loop setting into the legal range
    function automatic logic [2:0] ldo_clamp(input logic [2:0] v);
        if (v < LDO_LOOPS_MIN)
            return LDO_LOOPS_MIN;
        else if (v > LDO_LOOPS_MAX)
            return LDO_LOOPS_MAX;
        else
            return v;
    endfunction : ldo_clamp

    // Two-stage synchronisers for all pin inputs
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            occ_s1_r <= 2'h0;
            occ_s2_r <= 2'h0;
            fail_s1_r <= 2'h0;
            fail_s2_r <= 2'h0;
            grn_s1_r <= 2'h3;
            grn_s2_r <= 2'h3;
        end else begin
            occ_s1_r <= occ_pin;
            occ_s2_r <= occ_s1_r;
            fail_s1_r <= loop_fail_pin;
            fail_s2_r <= fail_s1_r;
            grn_s1_r <= phase_green_n;
            grn_s2_r <= grn_s1_r;
        end
    end

    // Filter setting change pulses a whole-detector reset
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            filt_r <= 1'b0;
            det_reset <= 1'b0;
        end else begin
            filt_r <= filt_off;
            det_reset <= (filt_off != filt_r);
        end
    end

    // Channel cores; one filter setting serves both
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            ldo_chan #(
                .EXT_W(EXT_W),
                .DES_CYC(DES_CYC)
            ) u_ch (
                .mclk(mclk),
                .rstn(rstn && !det_reset),
                .filt_off(filt_r),
                .occ_raw(occ_s2_r[gi]),
                .green(!grn_s2_r[gi]),
                .ext_cyc(ext_cyc[gi]),
                .timers_off(timers_off[gi]),
                .call_in(call_r[gi]),
                .cfg(ch_cfg[gi]),
                .occ(occ[gi]),
                .ext_run(ext_run[gi]),
                .disc(disc[gi]),
                .desens(desens[gi]),
                .count(count[gi])
            );
            assign chan_call[gi] = (occ[gi] || ext_run[gi]) && !disc[gi];
        end
    endgenerate

    // First detector of the pair runs no timers under directional logic
    assign timers_off = (dir_logic_en && dir_r != LDO_DIR_IDLE) ? first_r : 2'b00;

    // Directional sequencer: remember who detected first
    always_ff @(posedge mclk) begin
        if (!rstn || det_reset || !dir_logic_en) begin
            dir_r <= LDO_DIR_IDLE;
            first_r <= 2'b00;
        end else begin
            unique case (dir_r)
                LDO_DIR_IDLE: begin
                    if (occ == 2'b01 || occ == 2'b10) begin
                        dir_r <= LDO_DIR_PEND;
                        first_r <= occ;
                    end
                end
                LDO_DIR_PEND: begin
                    if (occ == 2'b11)
                        dir_r <= LDO_DIR_CALL;
                    else if ((occ & first_r) == 2'b00) begin
                        dir_r <= LDO_DIR_IDLE;
                        first_r <= 2'b00;
                    end
                end
                LDO_DIR_CALL: begin
                    if (!chan_call[first_r[0]] && !(|(occ & first_r))) begin
                        dir_r <= LDO_DIR_IDLE;
                        first_r <= 2'b00;
                    end
                end
                default: begin
                    dir_r <= LDO_DIR_IDLE;
                    first_r <= 2'b00;
                end
            endcase
        end
    end

    // Paired-channel call and pending logic, fail combine
    always_comb begin
        call_nxt = chan_call;
        pend_nxt = 2'b00;
        if (dir_logic_en) begin
            call_nxt = 2'b00;
            if (dir_r == LDO_DIR_PEND)
                pend_nxt = first_r;
            else if (dir_r == LDO_DIR_CALL)
                call_nxt = chan_call & ~first_r;
        end else if (third_car_en) begin
            call_nxt = (occ == 2'b11) ? chan_call : 2'b00;
            pend_nxt = (occ == 2'b01 || occ == 2'b10) ? occ : 2'b00;
        end
        fail_nxt = fail_s2_r;
        if (common_fail_en && |fail_s2_r)
            fail_nxt = 2'b11;
        call_nxt = call_nxt | fail_nxt;
    end

    // Registered status outputs
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ch_sts <= '0;
            call_r <= 2'b00;
        end else begin
            call_r <= call_nxt;
            for (int i = 0; i < 2; i++) begin
                ch_sts[i].call <= call_nxt[i];
                ch_sts[i].fail <= fail_nxt[i];
                ch_sts[i].pending <= pend_nxt[i];
                ch_sts[i].ext_run <= ext_run[i];
                ch_sts[i].desens <= desens[i];
            end
        end
    end

    // Audible select: one channel only, newest request wins
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            aud_r <= 2'b00;
            aud_req_d_r <= 2'b00;
            aud_cnt_r <= 64'h0;
        end else begin
            aud_req_d_r <= {ch_cfg[1].aud_req, ch_cfg[0].aud_req};
            if (ch_cfg[0].aud_req && !aud_req_d_r[0]) begin
                aud_r <= 2'b01;
                aud_cnt_r <= 64'h0;
            end else if (ch_cfg[1].aud_req && !aud_req_d_r[1]) begin
                aud_r <= 2'b10;
                aud_cnt_r <= 64'h0;
            end else if (aud_r != 2'b00) begin
                if (aud_cnt_r == 64'(AUD_CYC - 1))
                    aud_r <= 2'b00;
                else
                    aud_cnt_r <= aud_cnt_r + 64'h1;
            end
        end
    end

    // Buzzer follows filtered occupancy, not timers or disconnect
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            buzzer <= 1'b0;
            aud_sel <= 2'b00;
        end else begin
            buzzer <= |(aud_r & occ);
            aud_sel <= aud_r;
        end
    end

    // Loop setting held per channel within 1..5
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            loops_r <= {LDO_LOOPS_MIN, LDO_LOOPS_MIN};
            loops_cfg <= {LDO_LOOPS_MIN, LDO_LOOPS_MIN};
            cnt_reset_view <= 2'b00;
        end else begin
            loops_r[0] <= ldo_clamp(ch_cfg[0].loops);
            loops_r[1] <= ldo_clamp(ch_cfg[1].loops);
            loops_cfg <= loops_r;
            cnt_reset_view <= 2'b00; // Always shown as off
        end
    end

    // Alternation clock for large counts
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            alt_cnt_r <= 32'h0;
            alt_r <= 1'b0;
        end else if (alt_cnt_r == 32'(ALT_CYC - 1)) begin
            alt_cnt_r <= 32'h0;
            alt_r <= !alt_r;
        end else begin
            alt_cnt_r <= alt_cnt_r + 32'h1;
        end
    end

    // Count display: low three digits, or alternate high/low
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cnt_disp <= '0;
            cnt_disp_on <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                cnt_disp_on[i] <= ch_cfg[i].cnt_disp_en;
                if (count[i] > LDO_CNT_DISP_LIM && alt_r) begin
                    cnt_disp[i].upper <= 1'b1;
                    cnt_disp[i].value <= 10'(count[i] / 16'd1000);
                end else begin
                    cnt_disp[i].upper <= 1'b0;
                    cnt_disp[i].value <= 10'(count[i] % 16'd1000);
                end
            end
        end
    end

    // Third-car calls appear only with both loops occupied
    third_car_a: assert property (@(posedge mclk) disable iff (!rstn)
        (third_car_en && !dir_logic_en && occ != 2'b11 && fail_nxt == 2'b00)
        |=> ch_sts[0].call == 1'b0 && ch_sts[1].call == 1'b0)
        else $error("third car call without both loops");
    common_fail_a: assert property (@(posedge mclk) disable iff (!rstn)
        (common_fail_en && |fail_s2_r) |=> ch_sts[0].fail && ch_sts[1].fail)
        else $error("common fail not on both");
    aud_one_a: assert property (@(posedge mclk) disable iff (!rstn)
        aud_sel != 2'b11)
        else $error("audible on both channels");
    buzz_follow_a: assert property (@(posedge mclk) disable iff (!rstn)
        (aud_r[0] && occ[0]) |=> buzzer)
        else $error("buzzer missed occupancy");
    filt_reset_a: assert property (@(posedge mclk) disable iff (!rstn)
        $changed(filt_r) |-> det_reset)
        else $error("filter change without reset");
    dir_pend_a: assert property (@(posedge mclk) disable iff (!rstn)
        (dir_logic_en && dir_r == LDO_DIR_PEND) |=> ch_sts[0].call == $past(fail_nxt[0]))
        else $error("call while pending");
    sequence ldo_first_s;
        dir_logic_en && dir_r == LDO_DIR_CALL;
    endsequence
    dir_first_a: assert property (@(posedge mclk) disable iff (!rstn)
        ldo_first_s |-> ((ext_run & first_r) == 2'b00))
        else $error("first channel timers running");
    disp_low_a: assert property (@(posedge mclk) disable iff (!rstn)
        (count[0] <= LDO_CNT_DISP_LIM) |=> !cnt_disp[0].upper)
        else $error("upper digits shown for small count");
endmodule : ldo_top

/* dv/ldo_ctrl_model.sv */
// Traffic controller model: drives the active-low phase green inputs.
// Assumes the bench asks for green per channel; pins change at posedge.
module ldo_ctrl_model (
    input wire logic mclk,
    input wire logic [1:0] green_req,
    output logic [1:0] phase_green_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle level is not green, so a detector starts in normal operation
    initial begin
        phase_green_n = 2'h3;
    end
    // Green is active low; non-blocking on the edge, so the bench's falling-edge request never races
    always @(posedge mclk) begin
        phase_green_n <= ~green_req;
    end
endmodule : ldo_ctrl_model

/* dv/loop_detector_channel_options_bench.sv */
// Self-checking bench for the loop detector option logic.
// Assumes ldo_pkg and ldo_top compiled first; short counts set by parameters.
module loop_detector_channel_options_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import ldo_pkg::*;
    localparam int AUD = 1000;
    localparam int DES = 100;
    localparam int ALT = 10;
    typedef struct packed {
        logic [3:0] sel;
        logic [15:0] exp;
    } ldo_note_t;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] occ_pin = 2'h0;
    logic [1:0] loop_fail_pin = 2'h0;
    logic [1:0] green_req = 2'h0;
    logic [1:0] phase_green_n;
    logic filt_off = 1'b0;
    logic common_fail_en = 1'b0;
    logic third_car_en = 1'b0;
    logic dir_logic_en = 1'b0;
    ldo_chcfg_t [1:0] ch_cfg = '0;
    logic [1:0][31:0] ext_cyc = '0;
    ldo_chsts_t [1:0] ch_sts;
    logic [1:0] cnt_disp_on;
    ldo_disp_t [1:0] cnt_disp;
    logic [1:0] aud_sel;
    logic buzzer;
    logic [1:0] cnt_reset_view;
    logic [1:0][2:0] loops_cfg;
    logic det_reset;
    ldo_note_t exp_q[$];
    int mismatches = 0;
    int num_checks = 0;

    // 250 MHz clock
    always #2 mclk = ~mclk;

    ldo_top #(.EXT_W(32), .AUD_CYC(AUD), .DES_CYC(DES), .ALT_CYC(ALT)) i_dut (
        .mclk(mclk),
        .rstn(rstn),
        .occ_pin(occ_pin),
        .loop_fail_pin(loop_fail_pin),
        .phase_green_n(phase_green_n),
        .filt_off(filt_off),
        .common_fail_en(common_fail_en),
        .third_car_en(third_car_en),
        .dir_logic_en(dir_logic_en),
        .ch_cfg(ch_cfg),
        .ext_cyc(ext_cyc),
        .ch_sts(ch_sts),
        .cnt_disp_on(cnt_disp_on),
        .cnt_disp(cnt_disp),
        .aud_sel(aud_sel),
        .buzzer(buzzer),
        .cnt_reset_view(cnt_reset_view),
        .loops_cfg(loops_cfg),
        .det_reset(det_reset)
    );

    ldo_ctrl_model i_ctrl (
        .mclk(mclk),
        .green_req(green_req),
        .phase_green_n(phase_green_n)
    );

    // Output field picked by a note's selector
    function automatic logic [15:0] observe(input logic [3:0] sel);
        case (sel)
            4'h0: return {14'h0, ch_sts[1].call, ch_sts[0].call};
            4'h1: return {14'h0, ch_sts[1].fail, ch_sts[0].fail};
            4'h2: return {14'h0, ch_sts[1].pending, ch_sts[0].pending};
            4'h3: return {14'h0, aud_sel};
            4'h4: return {15'h0, buzzer};
            4'h5: return {15'h0, det_reset};
            4'h6: return {5'h0, cnt_disp[0]};
            4'h7: return {10'h0, loops_cfg};
            4'h8: return {ch_sts[1].desens, ch_sts[0].desens};
            4'h9: return {14'h0, cnt_reset_view};
            4'ha: return {14'h0, ch_sts[1].ext_run, ch_sts[0].ext_run};
            4'hc: return {5'h0, cnt_disp[1]};
            default: return {14'h0, cnt_disp_on};
        endcase
    endfunction : observe

    // Watcher: takes the oldest note and compares it with the outputs
    initial begin : watch
        ldo_note_t n;
        forever begin
            wait (exp_q.size() != 0);
            n = exp_q.pop_front();
            num_checks++;
            if (observe(n.sel) !== n.exp) begin
                mismatches++;
                $display("[ERR] %0t sel %0d got %h exp %h", $time, n.sel, observe(n.sel), n.exp);
            end
        end
    end

    // Note an expectation and let the watcher consume it in this step
    task automatic chk(input logic [3:0] sel, input logic [15:0] exp);
        exp_q.push_back('{sel, exp});
        wait (exp_q.size() == 0);
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc

    // One vehicle over a loop, driven on falling edges
    task automatic veh(input int ch, input int len, input int gap);
        occ_pin[ch] = 1'b1;
        cyc(len);
        occ_pin[ch] = 1'b0;
        cyc(gap);
    endtask : veh

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    // Whole run is near 8k cycles; 20k cycles means a hang
    initial begin : watchdog
        #80000;
        mismatches++;
        wrap_up();
    end

    initial begin : main
        int i;
        int e;
        void'($urandom(32'hdc4c231f));
        ch_cfg[0].loops = 3'h1;
        ch_cfg[1].loops = 3'h1;
        cyc(2);
        rstn = 1'b1;
        cyc(1);
        chk(4'h0, 16'h0000);
        chk(4'h9, 16'h0000);
        chk(4'h7, 16'h0009);
        // Filter in use: 10 cycles is too short, a long stay passes
        occ_pin[0] = 1'b1;
        cyc(10);
        chk(4'h0, 16'h0000);
        cyc(20);
        chk(4'h0, 16'h0001);
        occ_pin[0] = 1'b0;
        cyc(30);
        filt_off = 1'b1;
        for (i = 0; i < 6 && det_reset !== 1'b1; i++) cyc(1);
        chk(4'h5, 16'h0001);
        cyc(1);
        chk(4'h5, 16'h0000);
        cyc(4);
        occ_pin[0] = 1'b1;
        cyc(5);
        chk(4'h0, 16'h0001);
        occ_pin[0] = 1'b0;
        cyc(8);
        // Fail on one channel, then shared
        loop_fail_pin[0] = 1'b1;
        cyc(6);
        chk(4'h1, 16'h0001);
        common_fail_en = 1'b1;
        cyc(4);
        chk(4'h1, 16'h0003);
        loop_fail_pin[0] = 1'b0;
        common_fail_en = 1'b0;
        cyc(8);
        // Paired AND: ch1 first waits pending
        third_car_en = 1'b1;
        occ_pin[1] = 1'b1;
        cyc(8);
        chk(4'h0, 16'h0000);
        chk(4'h2, 16'h0002);
        occ_pin[0] = 1'b1;
        cyc(8);
        chk(4'h0, 16'h0003);
        occ_pin = 2'h0;
        cyc(8);
        chk(4'h0, 16'h0000);
        third_car_en = 1'b0;
        // Directional: ch0 first, ch1 later; ch0 extension must not run
        dir_logic_en = 1'b1;
        ext_cyc[0] = 32'd50;
        occ_pin[0] = 1'b1;
        cyc(8);
        chk(4'h0, 16'h0000);
        chk(4'h2, 16'h0001);
        occ_pin[1] = 1'b1;
        cyc(8);
        chk(4'h0, 16'h0002);
        occ_pin[0] = 1'b0;
        cyc(8);
        chk(4'h0, 16'h0002);
        chk(4'ha, 16'h0000);
        occ_pin[1] = 1'b0;
        cyc(8);
        chk(4'h0, 16'h0000);
        dir_logic_en = 1'b0;
        ext_cyc[0] = 32'd0;
        // Audible: select, follow occupancy, hand over, time out
        ch_cfg[0].aud_req = 1'b1;
        cyc(3);
        chk(4'h3, 16'h0001);
        occ_pin[0] = 1'b1;
        cyc(6);
        chk(4'h4, 16'h0001);
        occ_pin[0] = 1'b0;
        cyc(6);
        chk(4'h4, 16'h0000);
        ch_cfg[1].aud_req = 1'b1;
        cyc(3);
        chk(4'h3, 16'h0002);
        occ_pin[0] = 1'b1;
        cyc(6);
        chk(4'h4, 16'h0000);
        occ_pin[0] = 1'b0;
        cyc(AUD - 40);
        chk(4'h3, 16'h0002);
        cyc(60);
        chk(4'h3, 16'h0000);
        ch_cfg[0].aud_req = 1'b0;
        ch_cfg[1].aud_req = 1'b0;
        // Disconnect, sub-mode off, random gap time
        e = 20 + int'($urandom % 20);
        ext_cyc[0] = 32'(e);
        ch_cfg[0].disc_en = 1'b1;
        green_req[0] = 1'b1;
        cyc(6);
        veh(0, 5, e / 2);
        chk(4'h0, 16'h0001);
        chk(4'ha, 16'h0001);
        veh(0, 5, e - 6);
        chk(4'h0, 16'h0001);
        cyc(20);
        chk(4'h0, 16'h0000);
        occ_pin[0] = 1'b1;
        cyc(8);
        chk(4'h0, 16'h0000);
        occ_pin[0] = 1'b0;
        green_req[0] = 1'b0;
        cyc(8);
        occ_pin[0] = 1'b1;
        cyc(8);
        chk(4'h0, 16'h0001);
        occ_pin[0] = 1'b0;
        cyc(e + 10);
        // Sub-mode on: call follows occupancy, no extension
        ch_cfg[0].disc_sub = 1'b1;
        green_req[0] = 1'b1;
        cyc(8);
        occ_pin[0] = 1'b1;
        cyc(8);
        chk(4'h0, 16'h0001);
        occ_pin[0] = 1'b0;
        cyc(8);
        chk(4'h0, 16'h0000);
        chk(4'ha, 16'h0000);
        green_req[0] = 1'b0;
        ch_cfg[0].disc_en = 1'b0;
        ch_cfg[0].disc_sub = 1'b0;
        ext_cyc[0] = 32'd0;
        cyc(e + 10);
        // Desensitise only on ch0, only once green is active
        ch_cfg[0].pg_comp_en = 1'b1;
        occ_pin = 2'h3;
        cyc(DES + 20);
        chk(4'h8, 16'h0000);
        green_req = 2'h3;
        cyc(DES + 30);
        chk(4'h8, {8'h00, LDO_DES_HUND});
        occ_pin = 2'h0;
        green_req = 2'h0;
        ch_cfg[0].pg_comp_en = 1'b0;
        cyc(8);
        // Counting: clear, loop clamp, two loops per vehicle
        ch_cfg[0].cnt_disp_en = 1'b1;
        ch_cfg[0].cnt_reset = 1'b1;
        ch_cfg[0].loops = 3'h2;
        ch_cfg[1].loops = 3'h7;
        cyc(4);
        chk(4'h6, 16'h0000);
        chk(4'hb, 16'h0001);
        chk(4'h7, 16'h002a);
        chk(4'h9, 16'h0000);
        ch_cfg[0].cnt_reset = 1'b0;
        repeat (4) veh(0, 3 + int'($urandom % 4), 4);
        chk(4'h6, 16'h0002);
        ch_cfg[0].loops = 3'h1;
        ch_cfg[1].loops = 3'h0;
        ch_cfg[0].cnt_reset = 1'b1;
        cyc(4);
        chk(4'h7, 16'h0009);
        ch_cfg[0].cnt_reset = 1'b0;
        for (i = 0; i < 999; i++) veh(0, 3, 3);
        chk(4'h6, 16'h03e7);
        cyc(2 * ALT);
        chk(4'h6, 16'h03e7);
        veh(0, 3, 3);
        for (i = 0; i < 4 * ALT && cnt_disp[0].upper !== 1'b1; i++) cyc(1);
        chk(4'h6, 16'h0401);
        for (i = 0; i < 4 * ALT && cnt_disp[0].upper !== 1'b0; i++) cyc(1);
        chk(4'h6, 16'h0000);
        ch_cfg[0].cnt_disp_en = 1'b0;
        cyc(3);
        chk(4'hb, 16'h0000);
        chk(4'hc, 16'h0003);
        wrap_up();
    end
endmodule : loop_detector_channel_options_bench
